// [rtl/gcc_ctrl.sv]
`default_nettype none
// How it works
// - Eight compare codes select the test
// - True compare result inhibits destination write
// - Pixel-op top byte write starts operation
// - Suspend halts after memory cycle; clear resumes
// - Terminate aborts; moving registers become undefined
// - Completion always sets status; write one clears
// - Enabled completion also raises interrupt
// - Busy reads one while operation runs
// - Busy-time write flags access rejected; pointer and save writes are dropped, others complete
// - Control register writes never flag rejection
// - Two 32-bit ports, lengths A and B
// - Reads step through state, then reset
// - Saved state stays under one kilobyte
// - Big-endian swaps bytes except pixel-op and save-port reads
// - Only listed registers are directly readable
// - Error term moves during lines only
// - Source pointers move when source used
// - Pattern pointers move unless pattern fixed
// - Destination pointers move every operation
// - Masked bits excluded from compare test
module gcc_ctrl #(
  parameter int PIX_W = 8,
  parameter int OP_LEN = 16
) (
  input wire logic ref_clk_i,            // Clock, 125 MHz
  input wire logic sys_rst_i,            // Synchronous reset, high
  input wire logic big_endian_i,         // Register byte order select
  input wire logic reg_wr_i,             // Host write strobe
  input wire logic reg_rd_i,             // Host read strobe
  input wire logic [3:0] reg_addr_i,     // Register word index
  input wire logic [3:0] reg_be_i,       // Byte enables
  input wire logic [31:0] reg_wdata_i,   // Write data
  output logic [31:0] reg_rdata_o,       // Read data, registered
  output logic reg_rvalid_o,             // Read data valid pulse
  input wire logic mem_cycle_i,          // Memory cycle in progress
  input wire logic [PIX_W-1:0] dst_pix_i, // Destination pixel
  input wire logic [PIX_W-1:0] bit_mask_i, // Pixel bit mask
  output logic dst_wr_en_o,              // Destination write allowed
  output logic busy_o,                   // Operation running
  output logic irq_o                     // Interrupt request
);
  // ****************************************************
  // State machine
  // ****************************************************
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RUN = 4'b0010,
    ST_HOLD = 4'b0100,
    ST_DONE = 4'b1000
  } gcc_state_t;

  gcc_state_t state_ff;
  gcc_state_t nxt_state;
  logic [31:0] pixop_ff;
  logic [7:0] ctrl_ff;
  logic [1:0] irq_stat_ff;
  logic [1:0] irq_en_ff;
  logic [2:0] cmp_cond_ff;
  logic [PIX_W-1:0] cmp_val_ff;
  logic [31:0] err_ff;
  logic [31:0] src_xy_ff;
  logic [31:0] pat_xy_ff;
  logic [31:0] dst_xy_ff;
  logic [15:0] step_cnt_ff;
  logic [3:0] save_ptr_ff;
  logic [3:0] rest_ptr_ff;
  logic [31:0] wdata;
  logic [31:0] rd_mux;
  logic start;
  logic done;
  logic mem_wr;
  logic [2:0] mem_waddr;
  logic [31:0] mem_wdata;
  logic [31:0] mem_rdata;
  logic save_rd;
  logic cmp_true;
  logic [PIX_W-1:0] dst_m;
  logic [PIX_W-1:0] val_m;
  logic rd_pend_ff;
  logic rd_from_mem_ff;
  logic [31:0] rdata_ff;
  // ****************************************************
  // Host write path
  // ****************************************************
  // Pixel-op keeps its byte order since its lanes carry meaning
  always_comb begin
    if (big_endian_i && reg_addr_i != gcc_pkg::REG_PIXOP) begin
      wdata = {reg_wdata_i[7:0], reg_wdata_i[15:8], reg_wdata_i[23:16], reg_wdata_i[31:24]};
    end else begin
      wdata = reg_wdata_i;
    end
  end

  // Top byte lane is lane 3 in little-endian order
  assign start = reg_wr_i && reg_addr_i == gcc_pkg::REG_PIXOP && reg_be_i[3]
                 && state_ff == ST_IDLE;
  // Operation ends after a fixed step count or on terminate
  assign done = state_ff == ST_RUN && step_cnt_ff == 16'(OP_LEN - 1);
  // Pixel-op and compare registers
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      pixop_ff <= gcc_pkg::RST_WORD;
      cmp_cond_ff <= gcc_pkg::CMP_FALSE;
      cmp_val_ff <= '0;
    end else if (reg_wr_i) begin
      // Busy-time writes still land; the rejection flag warns the host
      if (reg_addr_i == gcc_pkg::REG_PIXOP) begin
        pixop_ff <= wdata;
      end
      if (reg_addr_i == gcc_pkg::REG_CMP) begin
        cmp_cond_ff <= wdata[10:8];
        cmp_val_ff <= wdata[PIX_W-1:0];
      end
    end
  end

  // Control register: suspend and terminate from host, busy from hardware
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ctrl_ff <= 8'h00;
    end else begin
      if (reg_wr_i && reg_addr_i == gcc_pkg::REG_CTRL) begin
        ctrl_ff[gcc_pkg::CTRL_SUSPEND] <= wdata[gcc_pkg::CTRL_SUSPEND];
        ctrl_ff[gcc_pkg::CTRL_TERM] <= wdata[gcc_pkg::CTRL_TERM];
      end else if (state_ff == ST_IDLE) begin
        ctrl_ff[gcc_pkg::CTRL_TERM] <= 1'b0;
      end
    end
  end

  // Interrupt enable register
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      irq_en_ff <= 2'h0;
    end else if (reg_wr_i && reg_addr_i == gcc_pkg::REG_IRQ_EN) begin
      irq_en_ff <= wdata[1:0];
    end
  end

  // ****************************************************
  // Operation sequencing
  // ****************************************************
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (start) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (ctrl_ff[gcc_pkg::CTRL_TERM]) begin
          nxt_state = ST_IDLE;
        end else if (ctrl_ff[gcc_pkg::CTRL_SUSPEND] && !mem_cycle_i) begin
          nxt_state = ST_HOLD;
        end else if (done) begin
          nxt_state = ST_DONE;
        end
      end
      ST_HOLD: begin
        if (ctrl_ff[gcc_pkg::CTRL_TERM]) begin
          nxt_state = ST_IDLE;
        end else if (!ctrl_ff[gcc_pkg::CTRL_SUSPEND]) begin
          nxt_state = ST_RUN;
        end
      end
      ST_DONE: nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  // Full save readout drops the state machine into its reset state, idle
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      state_ff <= ST_IDLE;
    end else if (save_rd && save_ptr_ff == 4'(gcc_pkg::SAVE_WORDS - 1)) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Step counter stands still while held
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || start) begin
      step_cnt_ff <= 16'h0000;
    end else if (state_ff == ST_RUN) begin
      step_cnt_ff <= step_cnt_ff + 16'h0001;
    end
  end

  assign busy_o = state_ff == ST_RUN || state_ff == ST_HOLD;
  // Sticky status: hardware set wins over a write-one clear
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      irq_stat_ff <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (reg_wr_i && reg_addr_i == gcc_pkg::REG_IRQ_STAT && wdata[i]) begin
          irq_stat_ff[i] <= 1'b0;
        end
      end
      if (state_ff == ST_DONE) begin
        irq_stat_ff[gcc_pkg::IRQ_DONE] <= 1'b1;
      end
      if (reg_wr_i && busy_o && reg_addr_i != gcc_pkg::REG_CTRL) begin
        irq_stat_ff[gcc_pkg::IRQ_REJ] <= 1'b1;
      end
    end
  end

  assign irq_o = |(irq_stat_ff & irq_en_ff);
  // ****************************************************
  // Pointers that move during an operation
  // ****************************************************
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      err_ff <= gcc_pkg::RST_WORD;
      src_xy_ff <= gcc_pkg::RST_WORD;
      pat_xy_ff <= gcc_pkg::RST_WORD;
      dst_xy_ff <= gcc_pkg::RST_WORD;
    end else if (state_ff == ST_RUN) begin
      if (pixop_ff[gcc_pkg::POP_LINE]) begin
        err_ff <= err_ff + 32'h0000_0001;
      end
      if (pixop_ff[gcc_pkg::POP_SRC_FG] || pixop_ff[gcc_pkg::POP_SRC_BG]) begin
        src_xy_ff <= src_xy_ff + 32'h0000_0001;
      end
      if (pixop_ff[gcc_pkg::POP_PAT_LSB +: 2] != gcc_pkg::POP_PAT_FIXED) begin
        pat_xy_ff <= pat_xy_ff + 32'h0000_0001;
      end
      dst_xy_ff <= dst_xy_ff + 32'h0000_0001;
    end else if (reg_wr_i && !busy_o) begin
      // Other registers hold across operations unless written
      case (reg_addr_i)
        gcc_pkg::REG_ERR: err_ff <= wdata;
        gcc_pkg::REG_SRC_XY: src_xy_ff <= wdata;
        gcc_pkg::REG_PAT_XY: pat_xy_ff <= wdata;
        gcc_pkg::REG_DST_XY: dst_xy_ff <= wdata;
        default: err_ff <= err_ff;
      endcase
    end
  end

  // ****************************************************
  // Colour compare
  // ****************************************************
  // Masked-off bits forced to zero on both sides of the test
  assign dst_m = dst_pix_i & bit_mask_i;
  assign val_m = cmp_val_ff & bit_mask_i;

  always_comb begin
    case (cmp_cond_ff)
      gcc_pkg::CMP_TRUE: cmp_true = 1'b1;
      gcc_pkg::CMP_GT: cmp_true = dst_m > val_m;
      gcc_pkg::CMP_EQ: cmp_true = dst_m == val_m;
      gcc_pkg::CMP_LT: cmp_true = dst_m < val_m;
      gcc_pkg::CMP_FALSE: cmp_true = 1'b0;
      gcc_pkg::CMP_GE: cmp_true = dst_m >= val_m;
      gcc_pkg::CMP_NE: cmp_true = dst_m != val_m;
      gcc_pkg::CMP_LE: cmp_true = dst_m <= val_m;
      default: cmp_true = 1'b0;
    endcase
  end

  // Registered so the write enable is clean at the memory
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      dst_wr_en_o <= 1'b0;
    end else begin
      dst_wr_en_o <= state_ff == ST_RUN && !cmp_true;
    end
  end

  // ****************************************************
  // Save and restore ports
  // ****************************************************
  // Ports A and B share one pointer over words 0..7: 32 bytes, far under 1 KB
  assign save_rd = reg_rd_i && (reg_addr_i == gcc_pkg::REG_SAVE_A
                   || reg_addr_i == gcc_pkg::REG_SAVE_B);
  assign mem_wr = reg_wr_i && !busy_o && (reg_addr_i == gcc_pkg::REG_SAVE_A
                  || reg_addr_i == gcc_pkg::REG_SAVE_B);
  assign mem_waddr = rest_ptr_ff[2:0];
  assign mem_wdata = wdata;

  // Read pointer walks the state in order; a full pass wraps to zero
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      save_ptr_ff <= 4'h0;
    end else if (save_rd) begin
      if (save_ptr_ff == 4'(gcc_pkg::SAVE_WORDS - 1)) begin
        save_ptr_ff <= 4'h0;
      end else begin
        save_ptr_ff <= save_ptr_ff + 4'h1;
      end
    end
  end

  // Restore takes words first-out first-in; a short count leaves it mid-way
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rest_ptr_ff <= 4'h0;
    end else if (mem_wr) begin
      if (rest_ptr_ff == 4'(gcc_pkg::SAVE_WORDS - 1)) begin
        rest_ptr_ff <= 4'h0;
      end else begin
        rest_ptr_ff <= rest_ptr_ff + 4'h1;
      end
    end
  end

  gcc_state_mem #(
    .DEPTH(gcc_pkg::SAVE_WORDS),
    .AW(3)
  ) u_mem (
    .ref_clk_i(ref_clk_i),
    .wr_en_i(mem_wr),
    .wr_addr_i(mem_waddr),
    .wr_data_i(mem_wdata),
    .rd_addr_i(save_rd ? save_ptr_ff[2:0] : save_ptr_ff[2:0] - 3'h1), // Hold last word read
    .rd_data_o(mem_rdata)
  );
  // ****************************************************
  // Host read path
  // ****************************************************
  // Unlisted registers read as zero; the save ports return only words written to them
  always_comb begin
    case (reg_addr_i)
      gcc_pkg::REG_CTRL: rd_mux = {24'h000000, busy_o, ctrl_ff[6:0]};
      gcc_pkg::REG_IRQ_STAT: rd_mux = {30'h0, irq_stat_ff};
      gcc_pkg::REG_LEN_A: rd_mux = {24'h000000, gcc_pkg::SAVE_LEN_A};
      gcc_pkg::REG_LEN_B: rd_mux = {24'h000000, gcc_pkg::SAVE_LEN_B};
      gcc_pkg::REG_ERR: rd_mux = err_ff;
      gcc_pkg::REG_SRC_XY: rd_mux = src_xy_ff;
      gcc_pkg::REG_PAT_XY: rd_mux = pat_xy_ff;
      gcc_pkg::REG_DST_XY: rd_mux = dst_xy_ff;
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  // Read data holds until the next read; save words arrive with the memory's lag
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rd_pend_ff <= 1'b0;
      rd_from_mem_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      rd_pend_ff <= reg_rd_i;
      rd_from_mem_ff <= reg_rd_i ? save_rd : rd_from_mem_ff;
      if (reg_rd_i && big_endian_i && reg_addr_i != gcc_pkg::REG_PIXOP) begin
        rdata_ff <= {rd_mux[7:0], rd_mux[15:8], rd_mux[23:16], rd_mux[31:24]};
      end else if (reg_rd_i) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  // Save words bypass the byte swap on read; restore writes are swapped in big-endian
  assign reg_rvalid_o = rd_pend_ff;
  assign reg_rdata_o = rd_from_mem_ff ? mem_rdata : rdata_ff;
endmodule
`default_nettype wire

// [rtl/gcc_pkg.sv]
`default_nettype none
package gcc_pkg;
  // ****************************************************
  // Compare conditions
  // ****************************************************
  localparam logic [2:0] CMP_TRUE = 3'h0;
  localparam logic [2:0] CMP_GT = 3'h1;
  localparam logic [2:0] CMP_EQ = 3'h2;
  localparam logic [2:0] CMP_LT = 3'h3;
  localparam logic [2:0] CMP_FALSE = 3'h4;
  localparam logic [2:0] CMP_GE = 3'h5;
  localparam logic [2:0] CMP_NE = 3'h6;
  localparam logic [2:0] CMP_LE = 3'h7;
  // ****************************************************
  // Register indexes (word addresses on the host port)
  // ****************************************************
  localparam logic [3:0] REG_PIXOP = 4'h0;
  localparam logic [3:0] REG_CTRL = 4'h1;
  localparam logic [3:0] REG_IRQ_STAT = 4'h2;
  localparam logic [3:0] REG_IRQ_EN = 4'h3;
  localparam logic [3:0] REG_SAVE_A = 4'h4;
  localparam logic [3:0] REG_SAVE_B = 4'h5;
  localparam logic [3:0] REG_LEN_A = 4'h6;
  localparam logic [3:0] REG_LEN_B = 4'h7;
  localparam logic [3:0] REG_ERR = 4'h8;
  localparam logic [3:0] REG_SRC_XY = 4'h9;
  localparam logic [3:0] REG_PAT_XY = 4'ha;
  localparam logic [3:0] REG_DST_XY = 4'hb;
  localparam logic [3:0] REG_CMP = 4'hc;
  // ****************************************************
  // Field positions
  // ****************************************************
  localparam int CTRL_SUSPEND = 3;
  localparam int CTRL_TERM = 5;
  localparam int CTRL_BUSY = 7;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_REJ = 1;
  localparam int POP_SRC_BG = 24;
  localparam int POP_SRC_FG = 25;
  localparam int POP_LINE = 26;
  localparam logic [1:0] POP_PAT_FIXED = 2'h3;
  localparam int POP_PAT_LSB = 28;
  // ****************************************************
  // Save state layout and reset values
  // ****************************************************
  localparam logic [7:0] SAVE_LEN_A = 8'h04;
  localparam logic [7:0] SAVE_LEN_B = 8'h04;
  localparam int SAVE_WORDS = 8;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
endpackage
`default_nettype wire

// [rtl/gcc_state_mem.sv]
`default_nettype none
// ****************************************************
// Small state memory, registered read port
// ****************************************************
module gcc_state_mem #(
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic ref_clk_i,      // Clock
  input wire logic wr_en_i,        // Write strobe
  input wire logic [AW-1:0] wr_addr_i, // Write address
  input wire logic [31:0] wr_data_i,   // Write data
  input wire logic [AW-1:0] rd_addr_i, // Read address
  output logic [31:0] rd_data_o    // Registered read data
);
  logic [31:0] mem_ff [DEPTH];
  // Contents need no reset; they are only read after a save fill
  always_ff @(posedge ref_clk_i) begin
    if (wr_en_i) begin
      mem_ff[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem_ff[rd_addr_i];
  end
endmodule
`default_nettype wire

// [testbench/gcc_ctrl_checker.sv]
`default_nettype none
// ****************************************
// Port checker for the coprocessor control
// ****************************************
module gcc_ctrl_checker #(
  parameter int PIX_W = 8,
  parameter int OP_LEN = 16
) (
  input wire logic ref_clk_i, // Clock
  input wire logic sys_rst_i, // Sync reset
  input wire logic big_endian_i, // Byte order
  input wire logic reg_wr_i, // Write strobe
  input wire logic reg_rd_i, // Read strobe
  input wire logic [3:0] reg_addr_i, // Index
  input wire logic [3:0] reg_be_i, // Byte enables
  input wire logic [31:0] reg_wdata_i, // Write data
  input wire logic [31:0] reg_rdata_o, // Read data
  input wire logic reg_rvalid_o, // Read valid
  input wire logic mem_cycle_i, // Memory cycle
  input wire logic [PIX_W-1:0] dst_pix_i, // Pixel
  input wire logic [PIX_W-1:0] bit_mask_i, // Mask
  input wire logic dst_wr_en_o, // Write allowed
  input wire logic busy_o, // Busy
  input wire logic irq_o // Interrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] en_ff;
  logic [2:0] cond_ff;
  // Shadows of enables and compare code; big-endian moves lane 0 to lane 3
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      en_ff <= 2'h0;
      cond_ff <= gcc_pkg::CMP_FALSE;
    end else if (reg_wr_i && reg_addr_i == gcc_pkg::REG_IRQ_EN) begin
      en_ff <= big_endian_i ? reg_wdata_i[25:24] : reg_wdata_i[1:0];
    end else if (reg_wr_i && reg_addr_i == gcc_pkg::REG_CMP) begin
      cond_ff <= big_endian_i ? reg_wdata_i[18:16] : reg_wdata_i[10:8];
    end
  end
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  sequence s_ctl_wr;
    reg_wr_i && reg_addr_i == gcc_pkg::REG_CTRL && busy_o && !big_endian_i;
  endsequence
  sequence s_susp;
    s_ctl_wr ##0 reg_wdata_i[gcc_pkg::CTRL_SUSPEND] ##[1:8] !mem_cycle_i ##3 1'b1;
  endsequence
  property p_start;
    reg_wr_i && reg_addr_i == gcc_pkg::REG_PIXOP && reg_be_i[3] && !busy_o
      |-> ##[1:2] busy_o ##1 busy_o [*3];
  endproperty
  a_start: assert property (p_start) else $error("start missed");
  property p_done;
    $fell(busy_o) && en_ff[0] |-> ##[0:2] irq_o;
  endproperty
  a_done: assert property (p_done) else $error("no completion irq");
  property p_noirq;
    irq_o |-> en_ff != 2'h0;
  endproperty
  a_noirq: assert property (p_noirq) else $error("irq while disabled");
  property p_rej;
    reg_wr_i && busy_o && reg_addr_i != gcc_pkg::REG_CTRL && en_ff[1] |-> ##[1:2] irq_o;
  endproperty
  a_rej: assert property (p_rej) else $error("no reject irq");
  property p_ctrl;
    s_ctl_wr ##0 !irq_o ##1 busy_o |-> !irq_o;
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control write flagged");
  property p_term;
    s_ctl_wr ##0 reg_wdata_i[gcc_pkg::CTRL_TERM] |-> ##[1:3] !busy_o;
  endproperty
  a_term: assert property (p_term) else $error("terminate ignored");
  property p_susp;
    s_susp |-> busy_o && !dst_wr_en_o;
  endproperty
  a_susp: assert property (p_susp) else $error("suspend did not halt");
  property p_wren;
    dst_wr_en_o |-> $past(busy_o) && $past(cond_ff) != gcc_pkg::CMP_TRUE;
  endproperty
  a_wren: assert property (p_wren) else $error("write not inhibited");
  property p_unl;
    reg_rd_i && reg_addr_i == gcc_pkg::REG_CMP |=> reg_rvalid_o && reg_rdata_o == 32'h0;
  endproperty
  a_unl: assert property (p_unl) else $error("unlisted read");
endmodule
bind gcc_ctrl gcc_ctrl_checker #(.PIX_W(PIX_W), .OP_LEN(OP_LEN)) i_chk (
  .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .big_endian_i(big_endian_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_be_i(reg_be_i),
  .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
  .mem_cycle_i(mem_cycle_i), .dst_pix_i(dst_pix_i), .bit_mask_i(bit_mask_i),
  .dst_wr_en_o(dst_wr_en_o), .busy_o(busy_o), .irq_o(irq_o));
`default_nettype wire

// [testbench/gcc_host.sv]
`default_nettype none
module gcc_host (
  input wire logic ref_clk_i, // Clock
  input wire logic [31:0] reg_rdata_i, // Read data
  output logic reg_wr_o, // Write strobe
  output logic reg_rd_o, // Read strobe
  output logic [3:0] reg_addr_o, // Index
  output logic [3:0] reg_be_o, // Byte enables
  output logic [31:0] reg_wdata_o // Write data
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 4'h0;
    reg_be_o = 4'h0;
    reg_wdata_o = 32'h0;
  end
  // Held from a falling edge over the sampling edge; data inverted after release
  task automatic put(input logic [3:0] a, input logic [3:0] be, input logic [31:0] d);
    @(negedge ref_clk_i);
    reg_addr_o = a;
    reg_be_o = be;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge ref_clk_i);
    reg_wr_o = 1'b0;
    reg_wdata_o = ~d;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    put(a, 4'hf, d);
  endtask
  // Data is registered, so it is taken a cycle and a half after the read edge
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(negedge ref_clk_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge ref_clk_i);
    reg_rd_o = 1'b0;
    @(negedge ref_clk_i);
    d = reg_rdata_i;
  endtask
  // Status cleared in either byte order before each start
  task automatic start(input logic [31:0] p);
    wr(gcc_pkg::REG_IRQ_STAT, 32'h0300_0003);
    put(gcc_pkg::REG_PIXOP, 4'h8, p);
  endtask
endmodule
`default_nettype wire

// [testbench/test_graphics_coprocessor_control.sv]
`default_nettype none
module test_graphics_coprocessor_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic big_endian_i = 1'b0;
  logic mem_cycle_i = 1'b0;
  logic [7:0] dst_pix_i = 8'h00;
  logic [7:0] bit_mask_i = 8'hff;
  logic reg_wr_i, reg_rd_i, reg_rvalid_o, dst_wr_en_o, busy_o, irq_o;
  logic [3:0] reg_addr_i, reg_be_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, rd, sa, pa, da, ea, pop;
  int n_errors = 0;
  int check_count = 0;
  int seed = 90;
  int wr_cnt = 0;
  int dv, mv, cv;
  logic [31:0] sq [$];
  // Long operation leaves room for reads and writes while busy
  gcc_ctrl #(.OP_LEN(40)) i_dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .big_endian_i(big_endian_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_be_i(reg_be_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .mem_cycle_i(mem_cycle_i),
    .dst_pix_i(dst_pix_i), .bit_mask_i(bit_mask_i), .dst_wr_en_o(dst_wr_en_o),
    .busy_o(busy_o), .irq_o(irq_o));
  gcc_host i_host (.ref_clk_i(ref_clk_i), .reg_rdata_i(reg_rdata_o), .reg_wr_o(reg_wr_i),
    .reg_rd_o(reg_rd_i), .reg_addr_o(reg_addr_i), .reg_be_o(reg_be_i),
    .reg_wdata_o(reg_wdata_i));
  always #4 ref_clk_i = ~ref_clk_i;
  // Count permitted destination writes
  always @(posedge ref_clk_i) if (dst_wr_en_o === 1'b1) wr_cnt++;
  // Reference of the compare test: true inhibits the write
  function automatic bit cmp_true(int c, int d, int v);
    case (c)
      0: return 1'b1;
      1: return d > v;
      2: return d == v;
      3: return d < v;
      5: return d >= v;
      6: return d != v;
      7: return d <= v;
      default: return 1'b0;
    endcase
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Bounded wait for the operation to end
  task automatic wait_idle();
    for (int k = 0; k < 300 && busy_o !== 1'b0; k++) @(negedge ref_clk_i);
    check(32'(busy_o), 32'h0);
  endtask
  task automatic run(input logic [31:0] p);
    wr_cnt = 0;
    i_host.start(p);
    @(negedge ref_clk_i);
    check(32'(busy_o), 32'h1);
  endtask
  initial begin
    #100000;
    n_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (2) @(negedge ref_clk_i);
    sys_rst_i = 1'b0;
    i_host.rd(gcc_pkg::REG_LEN_A, sa);
    check(sa, 32'(gcc_pkg::SAVE_LEN_A));
    i_host.rd(gcc_pkg::REG_LEN_B, pa);
    check(pa, 32'(gcc_pkg::SAVE_LEN_B));
    check(32'((sa + pa) * 4 < 1024), 32'h1);
    i_host.rd(gcc_pkg::REG_CMP, rd);
    check(rd, 32'h0);
    // Every compare code with random pixel, mask, value and operation flags
    for (int i = 0; i < 8; i++) begin
      dv = $random(seed) & 255;
      mv = $random(seed) & 255;
      cv = $random(seed) & 255;
      dst_pix_i = dv[7:0];
      bit_mask_i = mv[7:0];
      pop = $random(seed);
      i_host.wr(gcc_pkg::REG_IRQ_EN, (i == 0) ? 32'h0 : 32'h3);
      i_host.wr(gcc_pkg::REG_CMP, 32'((i << 8) | cv));
      i_host.rd(gcc_pkg::REG_SRC_XY, sa);
      i_host.rd(gcc_pkg::REG_PAT_XY, pa);
      i_host.rd(gcc_pkg::REG_DST_XY, da);
      i_host.rd(gcc_pkg::REG_ERR, ea);
      run(pop);
      wait_idle();
      check(32'(wr_cnt != 0), 32'(!cmp_true(i, dv & mv, cv & mv)));
      i_host.rd(gcc_pkg::REG_IRQ_STAT, rd);
      check(rd, 32'h1);
      check(32'(irq_o), 32'(i != 0));
      i_host.rd(gcc_pkg::REG_SRC_XY, rd);
      check(32'(rd != sa), 32'(pop[24] | pop[25]));
      i_host.rd(gcc_pkg::REG_PAT_XY, rd);
      check(32'(rd != pa), 32'(pop[29:28] != 2'h3));
      i_host.rd(gcc_pkg::REG_DST_XY, rd);
      check(32'(rd != da), 32'h1);
      i_host.rd(gcc_pkg::REG_ERR, rd);
      check(32'(rd != ea), 32'(pop[26]));
      i_host.wr(gcc_pkg::REG_IRQ_STAT, 32'h1);
      i_host.rd(gcc_pkg::REG_IRQ_STAT, rd);
      check(rd, 32'h0);
    end
    // Writes while busy: control exempt, compare flagged, then abort
    i_host.wr(gcc_pkg::REG_IRQ_EN, 32'h2);
    run(32'h0);
    i_host.wr(gcc_pkg::REG_CTRL, 32'h0);
    check(32'(irq_o), 32'h0);
    i_host.wr(gcc_pkg::REG_CMP, 32'h0000_0400);
    check(32'(irq_o), 32'h1);
    i_host.wr(gcc_pkg::REG_CTRL, 32'h20);
    repeat (3) @(negedge ref_clk_i);
    check(32'(busy_o), 32'h0);
    i_host.rd(gcc_pkg::REG_IRQ_STAT, rd);
    check(32'(rd[1]), 32'h1);
    // Suspend with a memory cycle outstanding, then resume
    i_host.wr(gcc_pkg::REG_IRQ_EN, 32'h0);
    run(32'h0);
    mem_cycle_i = 1'b1;
    i_host.wr(gcc_pkg::REG_CTRL, 32'h8);
    repeat (3) @(negedge ref_clk_i);
    mem_cycle_i = 1'b0;
    repeat (4) @(negedge ref_clk_i);
    i_host.rd(gcc_pkg::REG_DST_XY, da);
    repeat (5) @(negedge ref_clk_i);
    i_host.rd(gcc_pkg::REG_DST_XY, rd);
    check(rd, da);
    check(32'(busy_o), 32'h1);
    i_host.wr(gcc_pkg::REG_CTRL, 32'h0);
    wait_idle();
    i_host.rd(gcc_pkg::REG_IRQ_STAT, rd);
    check(rd, 32'h1);
    // Restore random words in order, then save them back out first-out first-in
    for (int k = 0; k < 8; k++) begin
      sq.push_back($random(seed));
      i_host.wr((k < 4) ? gcc_pkg::REG_SAVE_A : gcc_pkg::REG_SAVE_B, sq[k]);
    end
    for (int k = 0; k < 8; k++) begin
      i_host.rd((k < 4) ? gcc_pkg::REG_SAVE_A : gcc_pkg::REG_SAVE_B, rd);
      check(rd, sq.pop_front());
    end
    i_host.rd(gcc_pkg::REG_CTRL, rd);
    check(rd, 32'h0);
    // Big-endian lanes swap, operation start byte does not
    big_endian_i = 1'b1;
    i_host.wr(gcc_pkg::REG_IRQ_EN, 32'h0100_0000);
    run(32'h0);
    wait_idle();
    i_host.rd(gcc_pkg::REG_IRQ_STAT, rd);
    check(rd, 32'h0100_0000);
    check(32'(irq_o), 32'h1);
    i_host.rd(gcc_pkg::REG_LEN_A, rd);
    check(rd, {gcc_pkg::SAVE_LEN_A, 24'h0});
    tally_and_finish();
  end
endmodule
`default_nettype wire
